// ==== rtl/ocad_decoder.sv ====
module ocad_decoder #(
	parameter logic [ocad_pkg::CNT_W-1:0] WAIT_STATES = ocad_pkg::WAIT_STATES_DEF
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic req_valid_in,
	input wire ocad_pkg::ocad_req_s req_in,
	input wire logic boot_mode_in,
	input wire logic [1:0] flash_bank_busy_in,
	input wire logic [15:0] system_config_reg_in,
	input wire logic [15:0] periph_enable_reg_in,
	output logic req_ready_out,
	output logic done_out,
	output ocad_pkg::ocad_resp_s resp_out,
	output logic seg_limit_out
);
	import ocad_pkg::*;

	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	if (WAIT_STATES < 1) begin : g_bad_wait
		$error("WAIT_STATES must be at least one");
	end

	ocad_top_state_s st_reg;
	ocad_top_state_s st_next;
	logic take;
	logic glob_en;
	logic per_hit;
	ocad_target_e per_tgt;
	logic timer_start;
	logic timer_expire;
	ocad_target_e dec_tgt;
	ocad_err_e dec_err;
	logic dec_bank;
	logic dec_periph;
	logic dec_ram;

	assign take = req_valid_in && st_reg.ready;
	assign glob_en = system_config_reg_in[GLOBAL_EN_BIT];

	// ----------------------------------------------------------------
	// Peripheral window lookup
	// ----------------------------------------------------------------
	ocad_periph_decoder u_periph (
		.addr_in(req_in.addr),
		.eff_en_in(st_reg.eff_en),
		.hit_out(per_hit),
		.target_out(per_tgt)
	);

	// ----------------------------------------------------------------
	// Peripheral access wait states
	// ----------------------------------------------------------------
	ocad_wait_timer #(
		.CNT_W(CNT_W)
	) u_timer (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.start_in(timer_start),
		.load_in(WAIT_STATES),
		.expire_out(timer_expire)
	);

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	always_comb begin
		dec_tgt = TGT_EXT;
		dec_bank = 1'b0;
		if (boot_mode_in && in_range(req_in.addr, TFLASH_LO, TFLASH_HI)) begin
			dec_tgt = TGT_TFLASH;
		end else if (in_range(req_in.addr, FLASH_A_LO, FLASH_A_HI) ||
			in_range(req_in.addr, FLASH_B_LO, FLASH_B_HI)) begin
			dec_tgt = TGT_FLASH;
		end else if (in_range(req_in.addr, FLASH1_LO, FLASH1_HI)) begin
			dec_tgt = TGT_FLASH;
			dec_bank = 1'b1;
		end else if (in_range(req_in.addr, SFR_LO, SFR_HI) ||
			in_range(req_in.addr, ESFR_LO, ESFR_HI)) begin
			dec_tgt = TGT_SFR;
		end else if (in_range(req_in.addr, SRAM_LO, SRAM_HI)) begin
			if (st_reg.eff_en[SMALL_RAM_BIT]) begin
				dec_tgt = TGT_SRAM;
			end
		end else if (in_range(req_in.addr, LRAM_LO, LRAM_HI)) begin
			if (st_reg.eff_en[LARGE_RAM_BIT]) begin
				dec_tgt = TGT_LRAM;
			end
		end else if (per_hit) begin
			dec_tgt = per_tgt;
		end
	end

	assign dec_periph = (dec_tgt >= TGT_FIRST_CAN_MODULE);
	assign dec_ram = (dec_tgt == TGT_SRAM) || (dec_tgt == TGT_LRAM);

	// ----------------------------------------------------------------
	// Access checks
	// ----------------------------------------------------------------
	always_comb begin
		dec_err = ERR_NONE;
		if ((dec_tgt == TGT_FLASH || dec_tgt == TGT_TFLASH) && !req_in.write &&
			flash_bank_busy_in[dec_bank]) begin
			dec_err = ERR_BANK_BUSY;
		end else if (dec_ram && req_in.bit_acc) begin
			dec_err = ERR_BIT_ADDR;
		end else if (dec_ram && req_in.stack_acc) begin
			dec_err = ERR_STACK;
		end else if (dec_periph && req_in.byte_acc) begin
			dec_err = ERR_WIDTH;
		end
	end

	assign timer_start = take && dec_periph && (dec_err == ERR_NONE);

	// ----------------------------------------------------------------
	// Sequencer and enable capture
	// ----------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.glob_q = glob_en;
		if (!glob_en) begin
			st_next.eff_en = '0;
		end else if (!st_reg.glob_q) begin
			st_next.eff_en = periph_enable_reg_in[EN_W-1:0];
		end
		st_next.seg_limit = st_reg.eff_en[FIRST_CAN_BIT] || st_reg.eff_en[SECOND_CAN_BIT];
		st_next.done = 1'b0;
		case (st_reg.fsm)
			ST_IDLE: begin
				if (take) begin
					st_next.ready = 1'b0;
					st_next.resp.target = dec_tgt;
					st_next.resp.err = dec_err;
					st_next.resp.bank = dec_bank;
					st_next.resp.write = req_in.write;
					st_next.resp.byte_acc = req_in.byte_acc;
					st_next.resp.addr = req_in.addr;
					if (dec_tgt == TGT_EXT && st_next.seg_limit) begin
						st_next.resp.addr = req_in.addr & SEG_LIMIT_MASK;
					end
					if (timer_start) begin
						st_next.fsm = ST_WAIT;
					end else begin
						st_next.done = 1'b1;
						st_next.fsm = ST_DONE;
					end
				end
			end
			ST_WAIT: begin
				if (timer_expire) begin
					st_next.done = 1'b1;
					st_next.fsm = ST_DONE;
				end
			end
			ST_DONE: begin
				st_next.ready = 1'b1;
				st_next.fsm = ST_IDLE;
			end
			default: begin
				st_next.ready = 1'b1;
				st_next.fsm = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			st_reg <= '{fsm: ST_IDLE, ready: 1'b1, resp: '0, default: '0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign req_ready_out = st_reg.ready;
	assign done_out = st_reg.done;
	assign resp_out = st_reg.resp;
	assign seg_limit_out = st_reg.seg_limit;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	sequence s_periph_take;
		take && dec_periph && dec_err == ERR_NONE && WAIT_STATES == 2;
	endsequence

	sequence s_two_waits_then_done;
		!done_out [*2] ##1 done_out;
	endsequence

	AST_BOOT_TFLASH: assert property (
		take && boot_mode_in && req_in.addr <= TFLASH_HI |=> resp_out.target == TGT_TFLASH)
		else $error("bootstrap low access missed test flash");

	AST_USER_NO_TFLASH: assert property (
		take && !boot_mode_in |=> resp_out.target != TGT_TFLASH)
		else $error("test flash visible in user mode");

	AST_BANK1_BUSY: assert property (
		take && !req_in.write && flash_bank_busy_in[1] && req_in.addr >= FLASH1_LO &&
		req_in.addr <= FLASH1_HI |=> done_out && resp_out.err == ERR_BANK_BUSY)
		else $error("read of busy bank not refused");

	AST_OTHER_BANK_OK: assert property (
		take && flash_bank_busy_in[0] && !flash_bank_busy_in[1] && req_in.addr >= FLASH1_LO &&
		req_in.addr <= FLASH1_HI |=> resp_out.err == ERR_NONE)
		else $error("bank one refused for bank zero activity");

	AST_SRAM_ON: assert property (
		take && req_in.addr >= SRAM_LO && req_in.addr <= SRAM_HI &&
		st_reg.eff_en[SMALL_RAM_BIT] |=> resp_out.target == TGT_SRAM)
		else $error("small ram not selected");

	AST_SRAM_OFF: assert property (
		take && req_in.addr >= SRAM_LO && req_in.addr <= SRAM_HI &&
		!st_reg.eff_en[SMALL_RAM_BIT] |=> resp_out.target == TGT_EXT)
		else $error("disabled small ram not forwarded");

	AST_LRAM_GLOBAL_OFF: assert property (
		!glob_en ##1 take && req_in.addr >= LRAM_LO && req_in.addr <= LRAM_HI
		|=> resp_out.target == TGT_EXT)
		else $error("large ram decoded with global enable off");

	AST_RAM_ZERO_WAIT: assert property (
		take && dec_ram && !req_in.bit_acc && !req_in.stack_acc
		|=> done_out ##1 req_ready_out)
		else $error("extension ram access not zero wait");

	AST_RAM_BIT: assert property (
		take && dec_ram && req_in.bit_acc |=> resp_out.err == ERR_BIT_ADDR)
		else $error("bit access to extension ram accepted");

	AST_PERIPH_WAIT: assert property (
		s_periph_take |=> s_two_waits_then_done)
		else $error("peripheral access not two wait states");

	AST_PERIPH_BYTE: assert property (
		take && dec_periph && req_in.byte_acc |=> done_out && resp_out.err == ERR_WIDTH)
		else $error("byte access to peripheral accepted");

	AST_SEG_LIMIT: assert property (
		done_out && seg_limit_out && resp_out.target == TGT_EXT |->
		(resp_out.addr & ~SEG_LIMIT_MASK) == '0)
		else $error("segment lines not limited");

	AST_LATE_ENABLE: assert property (
		glob_en && st_reg.glob_q && $changed(periph_enable_reg_in) |=> $stable(st_reg.eff_en))
		else $error("late enable took effect");

	AST_EXT_UNCHANGED: assert property (
		take && dec_tgt == TGT_EXT && !st_next.seg_limit
		|=> resp_out.addr == $past(req_in.addr) && resp_out.err == ERR_NONE)
		else $error("external access altered");

	AST_FIRST_CAN_MODULE_SEL: assert property (
		take && req_in.addr[ADDR_W-1:8] == PERIPH_BASE[0][ADDR_W-1:8] && st_reg.eff_en[FIRST_CAN_BIT]
		|=> resp_out.target == TGT_FIRST_CAN_MODULE)
		else $error("first can window missed");

	AST_MISC_OFF: assert property (
		take && req_in.addr[ADDR_W-1:8] == PERIPH_BASE[7][ADDR_W-1:8] &&
		!st_reg.eff_en[PERIPH_BIT[7]] |=> resp_out.target == TGT_EXT)
		else $error("disabled misc window decoded");

	AST_FLASH_BANK0: assert property (
		take && in_range(req_in.addr, FLASH_B_LO, FLASH_B_HI)
		|=> resp_out.target == TGT_FLASH && !resp_out.bank)
		else $error("bank zero flash not selected");

	AST_FLASH_BANK1: assert property (
		take && in_range(req_in.addr, FLASH1_LO, FLASH1_HI)
		|=> resp_out.target == TGT_FLASH && resp_out.bank)
		else $error("bank one flash not selected");

	AST_LRAM_ON: assert property (
		take && in_range(req_in.addr, LRAM_LO, LRAM_HI) && st_reg.eff_en[LARGE_RAM_BIT]
		|=> resp_out.target == TGT_LRAM)
		else $error("large ram not selected");

	AST_SFR_SEL: assert property (
		take && (in_range(req_in.addr, SFR_LO, SFR_HI) ||
		in_range(req_in.addr, ESFR_LO, ESFR_HI))
		|=> resp_out.target == TGT_SFR)
		else $error("special function area not selected");

	AST_SECOND_CAN_MODULE_SEL: assert property (
		take && req_in.addr[ADDR_W-1:8] == PERIPH_BASE[1][ADDR_W-1:8] &&
		st_reg.eff_en[SECOND_CAN_BIT] |=> resp_out.target == TGT_SECOND_CAN_MODULE)
		else $error("second can window missed");

	AST_RTC_SEL: assert property (
		take && req_in.addr[ADDR_W-1:8] == PERIPH_BASE[2][ADDR_W-1:8] &&
		st_reg.eff_en[PERIPH_BIT[2]] |=> resp_out.target == TGT_RTC)
		else $error("real time clock window missed");

	AST_PWM_SEL: assert property (
		take && req_in.addr[ADDR_W-1:8] == PERIPH_BASE[3][ADDR_W-1:8] &&
		st_reg.eff_en[PERIPH_BIT[3]] |=> resp_out.target == TGT_PWM)
		else $error("bus pwm window missed");

	AST_RAM_STACK: assert property (
		take && dec_ram && !req_in.bit_acc && req_in.stack_acc |=> resp_out.err == ERR_STACK)
		else $error("stack access to extension ram accepted");

	AST_EXT_DONE: assert property (
		take && dec_tgt == TGT_EXT |=> done_out && resp_out.target == TGT_EXT)
		else $error("external access not forwarded at once");

	AST_BUSY_AFTER_TAKE: assert property (
		take |=> !req_ready_out)
		else $error("ready still high after a take");

	AST_RESP_WIDTH: assert property (
		take |=> resp_out.byte_acc == $past(req_in.byte_acc) &&
		resp_out.write == $past(req_in.write))
		else $error("access width or direction lost");
endmodule

// ==== rtl/ocad_pkg.sv ====
package ocad_pkg;
	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int ADDR_W = 24;
	localparam int EN_W = 11;
	localparam int CNT_W = 4;
	localparam int PERIPH_N = 8;
	typedef logic [ADDR_W-1:0] ocad_addr_t;

	// ----------------------------------------------------------------
	// Enable bit positions
	// ----------------------------------------------------------------
	localparam int GLOBAL_EN_BIT = 2;
	localparam int FIRST_CAN_BIT = 0;
	localparam int SECOND_CAN_BIT = 1;
	localparam int SMALL_RAM_BIT = 2;
	localparam int LARGE_RAM_BIT = 3;

	// ----------------------------------------------------------------
	// Address map
	// ----------------------------------------------------------------
	localparam ocad_addr_t TFLASH_LO = 24'h000000;
	localparam ocad_addr_t TFLASH_HI = 24'h001fff;
	localparam ocad_addr_t FLASH_A_LO = 24'h000000;
	localparam ocad_addr_t FLASH_A_HI = 24'h007fff;
	localparam ocad_addr_t FLASH_B_LO = 24'h018000;
	localparam ocad_addr_t FLASH_B_HI = 24'h06ffff;
	localparam ocad_addr_t FLASH1_LO = 24'h070000;
	localparam ocad_addr_t FLASH1_HI = 24'h08ffff;
	localparam ocad_addr_t SFR_LO = 24'h00fe00;
	localparam ocad_addr_t SFR_HI = 24'h00ffff;
	localparam ocad_addr_t ESFR_LO = 24'h00f000;
	localparam ocad_addr_t ESFR_HI = 24'h00f1ff;
	localparam ocad_addr_t SRAM_LO = 24'h00e000;
	localparam ocad_addr_t SRAM_HI = 24'h00e7ff;
	localparam ocad_addr_t LRAM_LO = 24'h0f0000;
	localparam ocad_addr_t LRAM_HI = 24'h0f7fff;
	localparam ocad_addr_t SEG_LIMIT_MASK = 24'h0fffff;
	localparam logic [CNT_W-1:0] WAIT_STATES_DEF = 4'h2;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		TGT_EXT, TGT_FLASH, TGT_TFLASH, TGT_SFR, TGT_SRAM, TGT_LRAM,
		TGT_FIRST_CAN_MODULE, TGT_SECOND_CAN_MODULE, TGT_RTC, TGT_PWM, TGT_ASC, TGT_SSC, TGT_I2C, TGT_MISC
	} ocad_target_e;
	typedef enum logic [2:0] {
		ERR_NONE, ERR_BANK_BUSY, ERR_WIDTH, ERR_BIT_ADDR, ERR_STACK
	} ocad_err_e;
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DONE} ocad_fsm_e;

	localparam ocad_addr_t PERIPH_BASE [PERIPH_N] = '{24'h00ef00, 24'h00ee00,
		24'h00ed00, 24'h00ec00, 24'h00e900, 24'h00e800, 24'h00ea00, 24'h00eb00};
	localparam int PERIPH_BIT [PERIPH_N] = '{0, 1, 4, 6, 7, 8, 9, 10};
	localparam ocad_target_e PERIPH_TGT [PERIPH_N] = '{TGT_FIRST_CAN_MODULE, TGT_SECOND_CAN_MODULE,
		TGT_RTC, TGT_PWM, TGT_ASC, TGT_SSC, TGT_I2C, TGT_MISC};

	typedef struct packed {
		ocad_addr_t addr;
		logic write;
		logic byte_acc;
		logic bit_acc;
		logic stack_acc;
	} ocad_req_s;

	typedef struct packed {
		ocad_target_e target;
		ocad_err_e err;
		logic bank;
		logic write;
		logic byte_acc;
		ocad_addr_t addr;
	} ocad_resp_s;

	typedef struct packed {
		ocad_fsm_e fsm;
		logic ready;
		logic done;
		logic seg_limit;
		logic glob_q;
		logic [EN_W-1:0] eff_en;
		ocad_resp_s resp;
	} ocad_top_state_s;

	function automatic logic in_range(ocad_addr_t a, ocad_addr_t lo, ocad_addr_t hi);
		return (a >= lo) && (a <= hi);
	endfunction
endpackage

// ==== rtl/ocad_periph_decoder.sv ====
module ocad_periph_decoder (
	input wire ocad_pkg::ocad_addr_t addr_in,
	input wire logic [ocad_pkg::EN_W-1:0] eff_en_in,
	output logic hit_out,
	output ocad_pkg::ocad_target_e target_out
);
	import ocad_pkg::*;

	// ----------------------------------------------------------------
	// Peripheral windows, 256 bytes each
	// ----------------------------------------------------------------
	always_comb begin
		hit_out = 1'b0;
		target_out = TGT_EXT;
		for (int i = 0; i < PERIPH_N; i++) begin
			if (addr_in[ADDR_W-1:8] == PERIPH_BASE[i][ADDR_W-1:8] && eff_en_in[PERIPH_BIT[i]]) begin
				hit_out = 1'b1;
				target_out = PERIPH_TGT[i];
			end
		end
	end
endmodule

// ==== rtl/ocad_wait_timer.sv ====
module ocad_wait_timer #(
	parameter int CNT_W = 4
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic start_in,
	input wire logic [CNT_W-1:0] load_in,
	output logic expire_out
);
	import ocad_pkg::*;

	if (CNT_W < 2) begin : g_bad_width
		$error("CNT_W must be at least two");
	end

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
	} ocad_timer_s;

	ocad_timer_s st_reg;
	ocad_timer_s st_next;

	// ----------------------------------------------------------------
	// Down counter; expires in its last counted cycle
	// ----------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		if (start_in) begin
			st_next.cnt = load_in;
		end else if (st_reg.cnt != '0) begin
			st_next.cnt = st_reg.cnt - 1'b1;
		end
	end

	assign expire_out = (st_reg.cnt == {{(CNT_W-1){1'b0}}, 1'b1});

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
endmodule

// ==== bench/ocad_cpu_model.sv ====
module ocad_cpu_model (
	input wire logic clk_in,
	input wire logic req_ready_in,
	input wire logic done_in,
	input wire ocad_pkg::ocad_resp_s resp_in,
	output logic req_valid_out,
	output ocad_pkg::ocad_req_s req_out
);
	timeunit 1ns;
	timeprecision 100ps;
	import ocad_pkg::*;

	initial begin
		req_valid_out = 1'b0;
		req_out = '0;
	end

	// ----------------------------------------------------------------
	// One access at a time
	// ----------------------------------------------------------------
	// One edge passes before the request rises, so two accesses in a row never
	// drive the strobe twice in one time step. The request is held until the
	// edge that sees ready high, then released with inverted address lines so a
	// stale value can never pass for a held one. The answer is taken while the
	// one-cycle done pulse stands; the latency counts edges from the take.
	task automatic access(input ocad_req_s q, output ocad_resp_s rs, output int lat);
		int n;
		n = 0;
		@(posedge clk_in);
		#1;
		req_valid_out = 1'b1;
		req_out = q;
		do begin
			@(posedge clk_in);
			n++;
		end while (!req_ready_in && n < 50);
		#1;
		req_valid_out = 1'b0;
		req_out = ~q;
		lat = 1;
		while (!done_in && lat < 20) begin
			@(posedge clk_in);
			#1;
			lat++;
		end
		rs = resp_in;
	endtask
endmodule

// ==== bench/onchip_address_decoder_tb.sv ====
module onchip_address_decoder_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import ocad_pkg::*;

	typedef struct packed {
		ocad_addr_t addr;
		logic [3:0] f;
		logic boot;
		logic [1:0] busy;
		ocad_target_e tgt;
		ocad_err_e err;
		logic [1:0] lat;
	} ocad_row_s;

	// Flags are write, byte, bit, stack from left to right.
	localparam ocad_row_s ROWS [31] = '{
		'{24'h000000, 4'h0, 1'b0, 2'h0, TGT_FLASH, ERR_NONE, 2'h1},
		'{24'h007fff, 4'h8, 1'b0, 2'h0, TGT_FLASH, ERR_NONE, 2'h1},
		'{24'h008000, 4'h0, 1'b0, 2'h0, TGT_EXT, ERR_NONE, 2'h1},
		'{24'h018000, 4'h4, 1'b0, 2'h0, TGT_FLASH, ERR_NONE, 2'h1},
		'{24'h08ffff, 4'h0, 1'b0, 2'h0, TGT_FLASH, ERR_NONE, 2'h1},
		'{24'h090000, 4'h0, 1'b0, 2'h0, TGT_EXT, ERR_NONE, 2'h1},
		'{24'h000000, 4'h0, 1'b1, 2'h0, TGT_TFLASH, ERR_NONE, 2'h1},
		'{24'h002000, 4'h0, 1'b1, 2'h0, TGT_FLASH, ERR_NONE, 2'h1},
		'{24'h000000, 4'h0, 1'b0, 2'h1, TGT_FLASH, ERR_BANK_BUSY, 2'h1},
		'{24'h070000, 4'h0, 1'b0, 2'h1, TGT_FLASH, ERR_NONE, 2'h1},
		'{24'h08ffff, 4'h0, 1'b0, 2'h2, TGT_FLASH, ERR_BANK_BUSY, 2'h1},
		'{24'h000000, 4'h8, 1'b0, 2'h1, TGT_FLASH, ERR_NONE, 2'h1},
		'{24'h00e000, 4'h4, 1'b0, 2'h0, TGT_SRAM, ERR_NONE, 2'h1},
		'{24'h00e7ff, 4'h8, 1'b0, 2'h0, TGT_SRAM, ERR_NONE, 2'h1},
		'{24'h00e000, 4'h2, 1'b0, 2'h0, TGT_SRAM, ERR_BIT_ADDR, 2'h1},
		'{24'h0f7fff, 4'h1, 1'b0, 2'h0, TGT_LRAM, ERR_STACK, 2'h1},
		'{24'h0f0000, 4'h4, 1'b0, 2'h0, TGT_LRAM, ERR_NONE, 2'h1},
		'{24'h0f8000, 4'h0, 1'b0, 2'h0, TGT_EXT, ERR_NONE, 2'h1},
		'{24'h00fe00, 4'h0, 1'b0, 2'h0, TGT_SFR, ERR_NONE, 2'h1},
		'{24'h00f1ff, 4'h8, 1'b0, 2'h0, TGT_SFR, ERR_NONE, 2'h1},
		'{24'h00f200, 4'h0, 1'b0, 2'h0, TGT_EXT, ERR_NONE, 2'h1},
		'{24'h00ef00, 4'h0, 1'b0, 2'h0, TGT_FIRST_CAN_MODULE, ERR_NONE, 2'h3},
		'{24'h00ee00, 4'h8, 1'b0, 2'h0, TGT_SECOND_CAN_MODULE, ERR_NONE, 2'h3},
		'{24'h00edff, 4'h0, 1'b0, 2'h0, TGT_RTC, ERR_NONE, 2'h3},
		'{24'h00ec80, 4'h8, 1'b0, 2'h0, TGT_PWM, ERR_NONE, 2'h3},
		'{24'h00e900, 4'h0, 1'b0, 2'h0, TGT_ASC, ERR_NONE, 2'h3},
		'{24'h00e8ff, 4'h0, 1'b0, 2'h0, TGT_SSC, ERR_NONE, 2'h3},
		'{24'h00ea00, 4'h8, 1'b0, 2'h0, TGT_I2C, ERR_NONE, 2'h3},
		'{24'h00eb00, 4'h0, 1'b0, 2'h0, TGT_MISC, ERR_NONE, 2'h3},
		'{24'h00ef00, 4'h4, 1'b0, 2'h0, TGT_FIRST_CAN_MODULE, ERR_WIDTH, 2'h1},
		'{24'h100000, 4'h0, 1'b0, 2'h0, TGT_EXT, ERR_NONE, 2'h1}
	};

	logic clk_in;
	logic rst_n_in;
	logic req_valid;
	ocad_req_s req;
	logic boot_mode_in;
	logic [1:0] flash_bank_busy_in;
	logic [15:0] system_config_reg_in;
	logic [15:0] periph_enable_reg_in;
	logic ready;
	logic done;
	ocad_resp_s resp;
	logic seg;
	logic seg_on;
	int mismatches;
	int checks_done;
	int cycles;

	ocad_decoder i_ocad_decoder (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.req_valid_in(req_valid),
		.req_in(req),
		.boot_mode_in(boot_mode_in),
		.flash_bank_busy_in(flash_bank_busy_in),
		.system_config_reg_in(system_config_reg_in),
		.periph_enable_reg_in(periph_enable_reg_in),
		.req_ready_out(ready),
		.done_out(done),
		.resp_out(resp),
		.seg_limit_out(seg)
	);

	ocad_cpu_model i_ocad_cpu_model (
		.clk_in(clk_in),
		.req_ready_in(ready),
		.done_in(done),
		.resp_in(resp),
		.req_valid_out(req_valid),
		.req_out(req)
	);

	// ----------------------------------------------------------------
	// Clock, timeout and reporting
	// ----------------------------------------------------------------
	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end

	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			final_report();
		end
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic ok, input string msg);
		checks_done++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	// Sets the global enable after the per-peripheral bits, as software must.
	task automatic enable(input logic [15:0] bits);
		system_config_reg_in = 16'h0000;
		step(2);
		periph_enable_reg_in = bits;
		step(1);
		system_config_reg_in = 16'h0004;
		step(3);
	endtask

	task automatic run(input ocad_addr_t a, input logic [3:0] f, input ocad_target_e t,
			input ocad_err_e e, input logic [1:0] l);
		ocad_resp_s rs;
		int lat;
		ocad_addr_t ea;
		ea = (t == TGT_EXT && seg_on) ? (a & SEG_LIMIT_MASK) : a;
		i_ocad_cpu_model.access('{a, f[3], f[2], f[1], f[0]}, rs, lat);
		check(rs.target === t && rs.err === e, "target or error code");
		check(lat == int'(l) && ready === 1'b0, "answer latency");
		check(rs.addr === ea && rs.write === f[3] && rs.byte_acc === f[2], "fields");
		if (t == TGT_FLASH || t == TGT_TFLASH) begin
			check(rs.bank === (a >= 24'h070000), "flash bank");
		end
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		rst_n_in = 1'b0;
		boot_mode_in = 1'b0;
		flash_bank_busy_in = 2'h0;
		system_config_reg_in = 16'h0000;
		periph_enable_reg_in = 16'h07df;
		seg_on = 1'b0;
		step(10);
		check(ready === 1'b1 && done === 1'b0 && resp === '0 && seg === 1'b0, "reset");
		rst_n_in = 1'b1;
		run(24'h00e000, 4'h4, TGT_EXT, ERR_NONE, 2'h1);
		run(24'h0f0000, 4'h0, TGT_EXT, ERR_NONE, 2'h1);
		run(24'h00ef00, 4'h0, TGT_EXT, ERR_NONE, 2'h1);
		enable(16'h07df);
		seg_on = 1'b1;
		check(seg === 1'b1, "segment limit with CAN");
		foreach (ROWS[i]) begin
			boot_mode_in = ROWS[i].boot;
			flash_bank_busy_in = ROWS[i].busy;
			run(ROWS[i].addr, ROWS[i].f, ROWS[i].tgt, ROWS[i].err, ROWS[i].lat);
		end
		boot_mode_in = 1'b0;
		flash_bank_busy_in = 2'h0;
		seg_on = 1'b0;
		enable(16'h0000);
		periph_enable_reg_in = 16'h000f;
		step(3);
		run(24'h00e000, 4'h0, TGT_EXT, ERR_NONE, 2'h1);
		run(24'h00ef00, 4'h0, TGT_EXT, ERR_NONE, 2'h1);
		check(seg === 1'b0, "late enable ignored");
		enable(16'h0004);
		run(24'h00e000, 4'h0, TGT_SRAM, ERR_NONE, 2'h1);
		run(24'h0f0000, 4'h0, TGT_EXT, ERR_NONE, 2'h1);
		run(24'h100000, 4'h0, TGT_EXT, ERR_NONE, 2'h1);
		enable(16'h0002);
		run(24'h00ee00, 4'h0, TGT_SECOND_CAN_MODULE, ERR_NONE, 2'h3);
		run(24'h00e000, 4'h0, TGT_EXT, ERR_NONE, 2'h1);
		check(seg === 1'b1, "segment limit with second CAN");
		rst_n_in = 1'b0;
		step(1);
		check(ready === 1'b1 && done === 1'b0 && seg === 1'b0, "reset in mid-run");
		rst_n_in = 1'b1;
		step(2);
		final_report();
	end
endmodule
